// ---- src/lbsc_pkg.sv ----
package lbsc_pkg;
  localparam logic [6:0] TARGET_ADDR       = 7'h31;
  localparam logic [7:0] REG_DIM_CFG       = 8'h00;
  localparam logic [7:0] REG_BOOST_CFG     = 8'h01;
  localparam logic [7:0] REG_LED_LEVEL     = 8'h02;
  localparam logic [7:0] REG_FAULT_CTL     = 8'h03;
  localparam logic [7:0] REG_DUTY          = 8'h04;
  localparam logic [7:0] REG_IDENT         = 8'h06;
  localparam logic [7:0] RST_DIM_CFG       = 8'h01;
  localparam logic [7:0] RST_BOOST_CFG     = 8'h54;
  localparam logic [7:0] RST_LED_LEVEL     = 8'h00;
  localparam logic [7:0] RST_FAULT_CTL     = 8'h80;
  localparam logic [7:0] RST_DUTY          = 8'h00;
  localparam logic [7:0] MASK_DIM_CFG      = 8'h97;
  localparam logic [7:0] MASK_BOOST_CFG    = 8'h7f;
  localparam logic [7:0] MASK_FAULT_CTL    = 8'h86;
  localparam int         BIT_SRC_SEL       = 2;
  localparam int         BIT_OC_CNT_EN     = 4;
  localparam int         BIT_OV_RESTART    = 7;
  localparam int         BIT_FLAG          = 0;
  localparam int         BIT_FLAG_CLR      = 3;
  localparam int         BIT_FAULT_EN      = 7;
  localparam int         BIT_WCHECK        = 7;
  localparam logic [7:0] OC_FAULT_RUN      = 8'h80;
  localparam logic [7:0] QUARTER_DUTY      = 8'h40;
  localparam logic [3:0] FREQ_CODE_MIN     = 4'h3;
  localparam logic [3:0] FREQ_CODE_MAX     = 4'h9;
  localparam int         CLK_MHZ           = 125;
  localparam int         STEP_KHZ          = 100;

  typedef enum logic [1:0] {
    LBSC_MODE_PULSE = 2'b00,
    LBSC_MODE_AMP   = 2'b01,
    LBSC_MODE_MIX_A = 2'b10,
    LBSC_MODE_MIX_B = 2'b11
  } lbsc_mode_e;

  typedef struct packed {
    logic       sink_on;
    logic [7:0] amp;
  } lbsc_led_s;
endpackage : lbsc_pkg

// ---- src/lbsc_smbus_if.sv ----
`timescale 1ns/1ps
// SMBus target byte engine; yields a register write or read-data fetch
module lbsc_smbus_if (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset_n,
  // Synchronised bus lines
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  // Register side
  input  wire logic [7:0] i_rd_data,
  output logic            o_sda_oe,
  output logic            o_wr,
  output logic [7:0]      o_addr,
  output logic [7:0]      o_wr_data
);
  import lbsc_pkg::*;

  typedef enum logic [2:0] {
    LBSC_IDLE  = 3'b000,
    LBSC_DEVAD = 3'b001,
    LBSC_PTR   = 3'b010,
    LBSC_WDAT  = 3'b011,
    LBSC_RDAT  = 3'b100,
    LBSC_ACK   = 3'b101,
    LBSC_RACK  = 3'b110
  } lbsc_bus_e;

  lbsc_bus_e  state;
  lbsc_bus_e  after_ack;
  logic       scl_d;
  logic       sda_d;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic       is_read;
  logic       phase_ptr;
  wire        scl_rise = i_scl & ~scl_d;
  wire        scl_fall = ~i_scl & scl_d;
  wire        start    = i_scl & scl_d & sda_d & ~i_sda;
  wire        stop     = i_scl & scl_d & ~sda_d & i_sda;

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= i_scl;
      sda_d <= i_sda;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state     <= LBSC_IDLE;
      after_ack <= LBSC_IDLE;
      shreg     <= 8'h00;
      bitcnt    <= 4'h0;
      is_read   <= 1'b0;
      phase_ptr <= 1'b0;
      o_sda_oe  <= 1'b0;
      o_wr      <= 1'b0;
      o_addr    <= 8'h00;
      o_wr_data <= 8'h00;
    end else begin
      o_wr <= 1'b0;
      if (start) begin
        state    <= LBSC_DEVAD;
        bitcnt   <= 4'h0;
        o_sda_oe <= 1'b0;
      end else if (stop) begin
        state    <= LBSC_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        unique case (state)
          LBSC_IDLE: begin
            o_sda_oe <= 1'b0;
          end
          LBSC_DEVAD, LBSC_PTR, LBSC_WDAT: begin
            if (scl_rise) begin
              shreg  <= {shreg[6:0], i_sda};
              bitcnt <= bitcnt + 4'h1;
            end
            if (scl_fall && bitcnt == 4'h8) begin
              bitcnt <= 4'h0;
              if (state == LBSC_DEVAD) begin
                // Foreign address: stay silent until next start
                if (shreg[7:1] == TARGET_ADDR) begin
                  is_read   <= shreg[0];
                  o_sda_oe  <= 1'b1;
                  after_ack <= shreg[0] ? LBSC_RDAT : LBSC_PTR;
                  state     <= LBSC_ACK;
                end else begin
                  state <= LBSC_IDLE;
                end
              end else if (state == LBSC_PTR) begin
                o_addr    <= shreg;
                o_sda_oe  <= 1'b1;
                after_ack <= LBSC_WDAT;
                state     <= LBSC_ACK;
              end else begin
                o_wr_data <= shreg;
                o_wr      <= 1'b1;
                o_sda_oe  <= 1'b1;
                after_ack <= LBSC_WDAT;
                state     <= LBSC_ACK;
              end
            end
          end
          LBSC_ACK: begin
            if (scl_fall) begin
              state  <= after_ack;
              bitcnt <= 4'h0;
              shreg  <= i_rd_data;
              // Read data drives low bits: oe high means drive zero
              o_sda_oe <= (after_ack == LBSC_RDAT) ? ~i_rd_data[7] : 1'b0;
              if (after_ack == LBSC_RDAT) begin
                bitcnt <= 4'h1;
              end
            end
          end
          LBSC_RDAT: begin
            if (scl_fall) begin
              if (bitcnt == 4'h8) begin
                o_sda_oe <= 1'b0;
                state    <= LBSC_RACK;
              end else begin
                o_sda_oe <= ~shreg[3'(7 - bitcnt)];
                bitcnt   <= bitcnt + 4'h1;
              end
            end
          end
          LBSC_RACK: begin
            if (scl_rise) begin
              if (i_sda) begin
                state <= LBSC_IDLE;
              end else begin
                o_addr    <= o_addr + 8'h01;
                after_ack <= LBSC_RDAT;
                state     <= LBSC_ACK;
              end
            end
          end
          default: state <= LBSC_IDLE;
        endcase
      end
    end
  end
endmodule : lbsc_smbus_if

// ---- src/lbsc_top.sv ----
`timescale 1ns/1ps
module lbsc_top #(
  parameter int         PERIOD_W  = 20,
  parameter logic [6:0] VENDOR_ID = 7'h15  // Arbitrary value
) (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset_n,
  // SMBus pins
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda_oe,
  // Dimming and analog status
  input  wire logic        i_dim_pwm,
  input  wire logic        i_overcurrent,
  input  wire logic        i_overvoltage,
  input  wire logic        i_switch_fault,
  // Boost and sink control
  output logic             o_boost_sw_en,
  output logic             o_ov_clamp,
  output logic             o_soft_restart,
  output logic [3:0]       o_boost_freq_step,
  output logic [1:0]       o_ocp_limit,
  output lbsc_pkg::lbsc_led_s o_led,
  output logic [7:0]       o_led_level,
  output logic             o_fault
);
  import lbsc_pkg::*;

  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic [1:0] pwm_s;
  logic [1:0] oc_s;
  logic [1:0] ov_s;
  logic [1:0] sf_s;
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scl_s <= 2'b11;
      sda_s <= 2'b11;
      pwm_s <= 2'b00;
      oc_s  <= 2'b00;
      ov_s  <= 2'b00;
      sf_s  <= 2'b00;
    end else begin
      scl_s <= {scl_s[0], i_scl};
      sda_s <= {sda_s[0], i_sda};
      pwm_s <= {pwm_s[0], i_dim_pwm};
      oc_s  <= {oc_s[0], i_overcurrent};
      ov_s  <= {ov_s[0], i_overvoltage};
      sf_s  <= {sf_s[0], i_switch_fault};
    end
  end

  logic       bus_wr;
  logic [7:0] bus_addr;
  logic [7:0] bus_wdata;
  logic [7:0] rd_data;
  lbsc_smbus_if u_smbus (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_scl     (scl_s[1]),
    .i_sda     (sda_s[1]),
    .i_rd_data (rd_data),
    .o_sda_oe  (o_sda_oe),
    .o_wr      (bus_wr),
    .o_addr    (bus_addr),
    .o_wr_data (bus_wdata)
  );

  logic [7:0] dim_cfg;
  logic [7:0] boost_cfg;
  logic [7:0] led_level;
  logic [7:0] fault_ctl;
  logic [7:0] reg_duty;
  logic       fault_flag;
  logic       ov_restart_req;

  // Writes masked to implemented bits; others dropped
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dim_cfg   <= RST_DIM_CFG;
      boost_cfg <= RST_BOOST_CFG;
      led_level <= RST_LED_LEVEL;
      fault_ctl <= RST_FAULT_CTL;
      reg_duty  <= RST_DUTY;
    end else if (ov_restart_req) begin
      // Overvoltage restart returns config to power-on values
      dim_cfg   <= RST_DIM_CFG;
      boost_cfg <= RST_BOOST_CFG;
      led_level <= RST_LED_LEVEL;
      fault_ctl <= RST_FAULT_CTL;
      reg_duty  <= RST_DUTY;
    end else if (bus_wr) begin
      unique case (bus_addr)
        REG_DIM_CFG:   dim_cfg   <= bus_wdata & MASK_DIM_CFG;
        REG_BOOST_CFG: boost_cfg <= bus_wdata & MASK_BOOST_CFG;
        REG_LED_LEVEL: led_level <= bus_wdata;
        REG_FAULT_CTL: fault_ctl <= bus_wdata & MASK_FAULT_CTL;
        REG_DUTY:      reg_duty  <= bus_wdata;
        default:       ;
      endcase
    end
  end

  always_comb begin
    unique case (bus_addr)
      REG_DIM_CFG:   rd_data = dim_cfg;
      REG_BOOST_CFG: rd_data = boost_cfg;
      REG_LED_LEVEL: rd_data = led_level;
      REG_FAULT_CTL: rd_data = {fault_ctl[7:1], fault_flag};
      REG_DUTY:      rd_data = reg_duty;
      REG_IDENT:     rd_data = {(led_level == 8'h00), VENDOR_ID};
      default:       rd_data = 8'h00;
    endcase
  end

  logic       oc_q;
  logic       oc_seen;
  logic [7:0] oc_run;
  logic       oc_tripped;
  logic       freq_tick;
  wire        flag_clr_wr = bus_wr && bus_addr == REG_FAULT_CTL && bus_wdata[BIT_FLAG_CLR];
  wire        oc_rise     = oc_s[1] & ~oc_q;
  wire        fault_event = fault_ctl[BIT_FAULT_EN] && (sf_s[1] || oc_tripped);

  // Each overcurrent pulse marks one switching cycle; only a whole tick-to-tick period
  // with no pulse breaks the run, so a gap that straddles a tick can leave it unbroken
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      oc_q       <= 1'b0;
      oc_seen    <= 1'b0;
      oc_run     <= 8'h00;
      oc_tripped <= 1'b0;
    end else begin
      oc_q <= oc_s[1];
      if (freq_tick) begin
        oc_seen <= oc_rise;
      end else if (oc_rise) begin
        oc_seen <= 1'b1;
      end
      if (!dim_cfg[BIT_OC_CNT_EN]) begin
        oc_run     <= 8'h00;
        oc_tripped <= 1'b0;
      end else if (freq_tick && !oc_seen && !oc_rise) begin
        oc_run <= 8'h00;
      end else if (oc_rise) begin
        if (oc_run == OC_FAULT_RUN - 8'h01) begin
          oc_tripped <= 1'b1;
        end else begin
          oc_run <= oc_run + 8'h01;
        end
      end
    end
  end

  // Set wins over a simultaneous clear
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fault_flag <= 1'b0;
    end else if (fault_event) begin
      fault_flag <= 1'b1;
    end else if (flag_clr_wr) begin
      fault_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_fault <= 1'b0;
    end else begin
      o_fault <= fault_flag | oc_tripped;
    end
  end

  // Switching frequency: codes clamp into 2..9 steps of 100 kHz
  wire [3:0]  freq_code = boost_cfg[3:0];
  wire [3:0]  freq_step = (freq_code < FREQ_CODE_MIN) ? 4'h2 :
                          (freq_code > FREQ_CODE_MAX) ? FREQ_CODE_MAX : freq_code;
  logic [15:0] freq_cnt;
  localparam logic [15:0] CYC_PER_STEP = 16'((CLK_MHZ * 1000) / STEP_KHZ);
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      freq_cnt  <= 16'h0000;
      freq_tick <= 1'b0;
    end else begin
      freq_tick <= 1'b0;
      if (freq_cnt >= CYC_PER_STEP / 16'(freq_step) - 16'h0001) begin
        freq_cnt  <= 16'h0000;
        freq_tick <= 1'b1;
      end else begin
        freq_cnt <= freq_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_boost_freq_step <= 4'h4;
      o_ocp_limit       <= 2'b00;
      o_led_level       <= 8'h00;
      o_boost_sw_en     <= 1'b0;
      o_ov_clamp        <= 1'b0;
      o_soft_restart    <= 1'b0;
      ov_restart_req    <= 1'b0;
    end else begin
      o_boost_freq_step <= freq_step;
      o_ocp_limit       <= {boost_cfg[4], 1'b0};
      o_led_level       <= led_level;
      // Cycle-by-cycle limit, no enable involved
      o_boost_sw_en     <= ~oc_s[1] & ~ov_s[1] & ~oc_tripped;
      o_ov_clamp        <= ov_s[1] & ~dim_cfg[BIT_OV_RESTART];
      ov_restart_req    <= ov_s[1] & dim_cfg[BIT_OV_RESTART] & ~ov_restart_req;
      o_soft_restart    <= ov_restart_req;
    end
  end

  // Duty meter on the pin: high time over period, latched per period
  logic [PERIOD_W-1:0] per_cnt;
  logic [PERIOD_W-1:0] hi_cnt;
  logic [7:0]          pin_duty;
  logic                pwm_q;
  wire                 pwm_rise = pwm_s[1] & ~pwm_q;
  wire [PERIOD_W+7:0]  hi_scaled = {hi_cnt, 8'h00} - {8'h00, hi_cnt};
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pwm_q    <= 1'b0;
      per_cnt  <= '0;
      hi_cnt   <= '0;
      pin_duty <= 8'h00;
    end else begin
      pwm_q <= pwm_s[1];
      if (pwm_rise) begin
        if (per_cnt != '0) begin
          pin_duty <= 8'(hi_scaled / {8'h00, per_cnt});
        end
        per_cnt <= PERIOD_W'(1);
        hi_cnt  <= PERIOD_W'(1);
      end else begin
        if (~&per_cnt) begin
          per_cnt <= per_cnt + PERIOD_W'(1);
        end
        if (pwm_s[1] && ~&hi_cnt) begin
          hi_cnt <= hi_cnt + PERIOD_W'(1);
        end
      end
    end
  end

  // Register source is used at once, no period wait
  wire        use_reg = dim_cfg[BIT_SRC_SEL];
  wire [7:0]  duty    = use_reg ? reg_duty : pin_duty;
  wire [15:0] scaled  = 16'(led_level) * 16'(duty);
  lbsc_mode_e mode;
  assign mode = lbsc_mode_e'(dim_cfg[1:0]);

  // Free 8-bit phase for internally generated pulse dimming
  logic [7:0] pulse_phase;
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pulse_phase <= 8'h00;
    end else begin
      pulse_phase <= pulse_phase + 8'h01;
    end
  end

  lbsc_led_s next_led;
  always_comb begin
    next_led.sink_on = 1'b1;
    next_led.amp     = led_level;
    unique case (mode)
      LBSC_MODE_PULSE: begin
        // Register source cannot drive pulse mode; fall back to pin
        next_led.sink_on = pwm_s[1];
      end
      LBSC_MODE_AMP: begin
        next_led.amp = scaled[15:8] + {7'h00, scaled[7]};
      end
      LBSC_MODE_MIX_A, LBSC_MODE_MIX_B: begin
        if (duty >= QUARTER_DUTY) begin
          next_led.amp = scaled[15:8] + {7'h00, scaled[7]};
        end else begin
          next_led.sink_on = use_reg ? (pulse_phase < duty) : pwm_s[1];
        end
      end
    endcase
    if (led_level == 8'h00) begin
      next_led.sink_on = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_led <= '0;
    end else begin
      o_led <= next_led;
    end
  end

  bus_addr_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    bus_addr == REG_IDENT |-> rd_data[BIT_WCHECK] == (led_level == 8'h00))
    else $error("written-check bit wrong");
  flag_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    fault_event |=> fault_flag)
    else $error("fault flag not set");
  flag_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (flag_clr_wr && !fault_event) |=> !fault_flag)
    else $error("fault flag not cleared");
  oc_switch_off_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    oc_s[1] |=> !o_boost_sw_en)
    else $error("switch on during overcurrent");
  oc_disabled_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !dim_cfg[BIT_OC_CNT_EN] |=> !oc_tripped)
    else $error("overcurrent trip while disabled");
  freq_clamp_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    ##1 (o_boost_freq_step >= 4'h2 && o_boost_freq_step <= 4'h9))
    else $error("frequency step out of range");
  pulse_follow_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (mode == LBSC_MODE_PULSE && led_level != 8'h00) |=> o_led.sink_on == $past(pwm_s[1]))
    else $error("pulse mode not following input");
  ov_clamp_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (ov_s[1] && !dim_cfg[BIT_OV_RESTART]) |=> o_ov_clamp && !ov_restart_req)
    else $error("overvoltage clamp response wrong");
  unused_rd_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (bus_addr > REG_IDENT || bus_addr == 8'h05) |-> rd_data == 8'h00)
    else $error("unused address reads nonzero");

  trip_c:   cover property (@(posedge i_clk_sys) disable iff (!i_reset_n) $rose(oc_tripped));
  mix_c:    cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    mode == LBSC_MODE_MIX_A && duty < QUARTER_DUTY);
  wr_c:     cover property (@(posedge i_clk_sys) disable iff (!i_reset_n) bus_wr);
  restart_c: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n) o_soft_restart);
endmodule : lbsc_top

// ---- verification/lbsc_bench.sv ----
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module lbsc_bench;
  import lbsc_pkg::*;
  logic       clk   = 1'b0;
  logic       rst_n = 1'b0;
  logic       ov    = 1'b0;
  logic       oc    = 1'b0;
  logic       swf   = 1'b0;
  logic       scl, sda, sda_oe, dim, sw_en, clamp, restart, fault, ack, seen;
  logic [3:0] fstep;
  logic [1:0] ocpl;
  logic [7:0] lvl, d;
  lbsc_led_s  led;
  int         num_errors  = 0;
  int         checks_done = 0;
  always #4 clk = ~clk;
  lbsc_top #(.PERIOD_W(20), .VENDOR_ID(7'h2a)) DUT (  // Identity value arbitrary
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_scl(scl), .i_sda(sda), .o_sda_oe(sda_oe),
    .i_dim_pwm(dim), .i_overcurrent(oc), .i_overvoltage(ov), .i_switch_fault(swf),
    .o_boost_sw_en(sw_en), .o_ov_clamp(clamp), .o_soft_restart(restart),
    .o_boost_freq_step(fstep), .o_ocp_limit(ocpl), .o_led(led), .o_led_level(lvl), .o_fault(fault));
  lbsc_host_model host (.i_clk_sys(clk), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda), .o_dim_pwm(dim));
  task automatic tally_and_finish();
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host.wr(a, v, ack);
    `CHK("write ack", 1'b1, ack)
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d, ack);
    `CHK("read ack", 1'b1, ack)
    `CHK("register", e, d)
  endtask : rchk
  // Waits for a dimming phase, samples the sinks mid-cycle, returns on a rising edge
  task automatic at_phase(input int p, input logic e);
    int i;
    for (i = 0; i < 300 && host.pc != p; i++) @(posedge clk);
    if (i == 300) begin
      num_errors++;
      tally_and_finish();
    end
    @(negedge clk);
    `CHK("sink state", e, led.sink_on)
    @(posedge clk);
  endtask : at_phase
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    cyc(4);
    rst_n <= 1'b1;
    cyc(4);
    `CHK("freq step", 4'h4, fstep)
    `CHK("ocp limit", 2'b10, ocpl)
    rchk(8'h00, 8'h01);
    rchk(8'h01, 8'h54);
    rchk(8'h02, 8'h00);
    rchk(8'h03, 8'h80);
    rchk(8'h04, 8'h00);
    rchk(8'h05, 8'h00);
    rchk(8'h06, 8'haa);
    host.start();
    host.send(8'h64, ack);
    host.stop();
    `CHK("foreign nack", 1'b0, ack)
    wr(8'h00, 8'hff);
    rchk(8'h00, 8'h97);
    wr(8'h01, 8'hff);
    rchk(8'h01, 8'h7f);
    wr(8'h03, 8'hff);
    rchk(8'h03, 8'h86);
    wr(8'h06, 8'h00);
    rchk(8'h06, 8'haa);
    for (int c = 0; c < 16; c++) begin
      wr(8'h01, 8'(c));
      cyc(4);
      `CHK("freq step", (c < 3) ? 4'h2 : (c > 9) ? 4'h9 : 4'(c), fstep)
    end
    wr(8'h02, 8'h80);
    `CHK("led level", 8'h80, lvl)
    rchk(8'h06, 8'h2a);
    host.pwm_hi = 128;
    // Half duty is above the mixed-mode threshold, so all three scale alike
    for (int m = 1; m < 4; m++) begin
      wr(8'h00, 8'(m));
      cyc(800);
      `CHK("amplitude", 8'h40, led.amp)
    end
    wr(8'h00, 8'h00);
    cyc(600);
    at_phase(60, 1'b1);
    at_phase(200, 1'b0);
    host.pwm_hi = 0;
    wr(8'h04, 8'h80);
    wr(8'h00, 8'h05);
    cyc(20);
    `CHK("reg amplitude", 8'h40, led.amp)
    wr(8'h04, 8'h00);
    cyc(20);
    `CHK("reg amplitude", 8'h00, led.amp)
    wr(8'h04, 8'h20);
    wr(8'h00, 8'h06);
    cyc(20);
    `CHK("mixed hold", 8'h80, led.amp)
    wr(8'h03, 8'h80);
    swf <= 1'b1;
    cyc(10);
    `CHK("fault out", 1'b1, fault)
    rchk(8'h03, 8'h81);
    swf <= 1'b0;
    wr(8'h03, 8'h88);
    rchk(8'h03, 8'h80);
    wr(8'h00, 8'h10);
    // Pulses well inside one switching period keep the run unbroken
    for (int i = 1; i <= 128; i++) begin
      oc <= 1'b1;
      cyc(5);
      `CHK("switch off", 1'b0, sw_en)
      oc <= 1'b0;
      cyc(35);
      if (i == 127) `CHK("early fault", 1'b0, fault)
    end
    `CHK("oc fault", 1'b1, fault)
    wr(8'h00, 8'h00);
    cyc(5);
    `CHK("switch on", 1'b1, sw_en)
    ov <= 1'b1;
    cyc(8);
    `CHK("clamp", 1'b1, clamp)
    ov <= 1'b0;
    wr(8'h00, 8'h80);
    seen = 1'b0;
    ov <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(negedge clk);
      seen = seen | restart;
    end
    `CHK("restart", 1'b1, seen)
    @(posedge clk) ov <= 1'b0;
    cyc(10);
    rchk(8'h00, 8'h01);
    tally_and_finish();
  end
endmodule : lbsc_bench

// ---- verification/lbsc_host_model.sv ----
`timescale 1ns/1ps
module lbsc_host_model
  import lbsc_pkg::*;
(
  // Clock
  input  wire logic i_clk_sys,
  // Bus and dimming lines
  input  wire logic i_sda_oe,
  output logic      o_scl,
  output logic      o_sda,
  output logic      o_dim_pwm
);
  logic sda_low = 1'b0;
  int   pwm_hi  = 0;
  int   pwm_per = 255;
  int   pc      = 0;
  initial begin
    o_scl     = 1'b1;
    o_dim_pwm = 1'b0;
  end
  // Open drain, pulled up when released
  assign o_sda = !(sda_low || i_sda_oe);
  // Period far shorter than 1 ms to keep the run short
  always @(posedge i_clk_sys) begin
    pc        <= (pc + 1 >= pwm_per) ? 0 : pc + 1;
    o_dim_pwm <= (pc < pwm_hi);
  end
  task automatic half();
    repeat (10) @(posedge i_clk_sys);
  endtask : half
  // Sampled mid-cycle so the device's own edge updates have landed
  task automatic pulse(output logic v);
    half();
    o_scl <= 1'b1;
    repeat (9) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    v = o_sda;
    @(posedge i_clk_sys);
    o_scl <= 1'b0;
  endtask : pulse
  task automatic start();
    sda_low <= 1'b0;
    half();
    o_scl <= 1'b1;
    half();
    sda_low <= 1'b1;
    half();
    o_scl <= 1'b0;
  endtask : start
  task automatic stop();
    sda_low <= 1'b1;
    half();
    o_scl <= 1'b1;
    half();
    sda_low <= 1'b0;
    half();
  endtask : stop
  task automatic send(input logic [7:0] b, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      sda_low <= !b[i];
      pulse(v);
    end
    sda_low <= 1'b0;
    pulse(v);
    ack = !v;
  endtask : send
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ack);
    logic k0, k1, k2;
    start();
    send(8'h62, k0);
    send(a, k1);
    send(d, k2);
    stop();
    ack = k0 & k1 & k2;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ack);
    logic k0, k1, k2, v;
    start();
    send(8'h62, k0);
    send(a, k1);
    start();
    send(8'h63, k2);
    sda_low <= 1'b0;
    for (int i = 7; i >= 0; i--) pulse(d[i]);
    pulse(v);
    stop();
    ack = k0 & k1 & k2;
  endtask : rd
endmodule : lbsc_host_model
